// *** hdl/ces_pkg.sv ***
package ces_pkg;

  // bus geometry
  localparam int          CES_AW         = 12;
  localparam int          CES_DW         = 32;
  localparam logic [1:0]  CES_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  CES_RESP_SLV   = 2'h2;

  // register indices, byte address is four times the index
  localparam logic [9:0]  CES_IDX_CTRL   = 10'h000;
  localparam logic [9:0]  CES_IDX_PEN    = 10'h001;
  localparam logic [9:0]  CES_IDX_SWCFG  = 10'h002;
  localparam logic [9:0]  CES_IDX_STAT   = 10'h003;
  localparam logic [9:0]  CES_IDX_TMO0   = 10'h008;
  localparam logic [9:0]  CES_IDX_LIMCFG = 10'h051;

  // control, switch and limit register fields
  localparam int          CES_CTRL_MODE_LSB = 0;
  localparam int          CES_CTRL_PWR_BIT  = 3;
  localparam int          CES_CTRL_ATT_BIT  = 4;
  localparam int          CES_CTRL_CF_BIT   = 5;
  localparam int          CES_CTRL_RTY_BIT  = 6;
  localparam int          CES_CTRL_TMO_BIT  = 7;
  localparam int          CES_SWCFG_HS_BIT  = 0;
  localparam int          CES_LIM_R2_LSB    = 2;

  // reset values
  localparam logic [7:0]  CES_CTRL_RST   = 8'hC0;
  localparam logic [7:0]  CES_PEN_RST    = 8'h7F;
  localparam logic [7:0]  CES_SWCFG_RST  = 8'h00;
  localparam logic [7:0]  CES_TMO_RST    = 8'h20;
  localparam logic [7:0]  CES_LIMCFG_RST = 8'h00;

  // profiles
  localparam int          CES_NPROF      = 8;
  localparam logic [2:0]  CES_PROF_L3    = 3'h2;
  localparam logic [2:0]  CES_PROF_CUST  = 3'h7;
  localparam logic [3:0]  CES_SIG_NONE   = 4'h0;
  localparam logic [3:0]  CES_SIG_DCP    = 4'h3;

  // timing
  localparam int          CES_CLK_NS     = 100;
  localparam int          CES_MS_NS      = 1000000;
  localparam int          CES_MS_CYCLES  = CES_MS_NS / CES_CLK_NS;
  localparam logic [7:0]  CES_DISCH_MS   = 8'h0A;
  localparam logic [7:0]  CES_RHOLD_MS   = 8'h32;
  localparam logic [7:0]  CES_HREST_MS   = CES_RHOLD_MS - CES_DISCH_MS;

  typedef enum logic [2:0] {
    CES_MODE_PASS = 3'h0,
    CES_MODE_SDP  = 3'h1,
    CES_MODE_CDP  = 3'h2,
    CES_MODE_DCP  = 3'h3,
    CES_MODE_DCE  = 3'h4
  } ces_mode_t;

  typedef enum logic [7:0] {
    CES_ST_IDLE   = 8'h01,
    CES_ST_DISCH  = 8'h02,
    CES_ST_HOLD   = 8'h04,
    CES_ST_APPLY  = 8'h08,
    CES_ST_CHARGE = 8'h10,
    CES_ST_NOHS   = 8'h20,
    CES_ST_DCP    = 8'h40,
    CES_ST_PASS   = 8'h80
  } ces_state_t;

endpackage : ces_pkg

// *** hdl/ces_sequencer.sv ***
// Notes on behaviour
// [RULE1] dcp mode: discharge vbus, then dcp signature
// [RULE2] standalone dcp: no timeout, no current check
// [RULE3] dcp charging: short on, switch open, cc
// [RULE4] dcp ignores data pin detection levels
// [RULE5] each profile timed; current checked at expiry
// [RULE6] data switch open while charging, unless configured
// [RULE7] emulation reset precedes every profile
// [RULE8] power switch held open, then reclosed
// [RULE9] order legacy one..seven, custom off default
// [RULE10] custom first bit puts custom first
// [RULE11] no attach detect: keep cycling profiles
// [RULE12] current above threshold at expiry: accept
// [RULE13] no current at expiry: reset, next profile
// [RULE14] per profile timeout, timeout enabled default
// [RULE15] all rejected, retry set: reset and restart
// [RULE16] all rejected, no retry: flag, end cycle
// [RULE17] pass-through and sdp use trip limiting
// [RULE18] cdp, dcp, applying profile: cc if low
// [RULE19] legacy three accepted: cc if low limit
// [RULE20] other accepted or no handshake: region two
// [RULE21] region two minimum from bits four..two
// [RULE22] no handshake flag set and stays set
// [RULE23] no handshake: signatures off, switch configured
// [RULE24] comparator inputs sampled at decision points
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ces_sequencer #(
  parameter int MS_TICK_CYCLES = ces_pkg::CES_MS_CYCLES
) (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite slave
  input  wire logic [ces_pkg::CES_AW-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [ces_pkg::CES_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [ces_pkg::CES_AW-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [ces_pkg::CES_DW-1:0]    s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // comparator and detector inputs
  input  wire logic                     charge_detect,
  input  wire logic                     ilim_below_thresh,
  input  wire logic                     r2min_below_limit,
  input  wire logic                     attach_detected,
  // analog controls
  output logic                          port_switch_close,
  output logic                          vbus_discharge,
  output logic                          pulldown_enable,
  output logic                          short_resistor_on,
  output logic                          hs_switch_close,
  output logic                          cc_limit_mode,
  output logic [3:0]                    signature_sel,
  output logic [2:0]                    region2_min_current,
  output logic                          handshake_missing_flag
);
  import ces_pkg::*;

  logic [7:0]   ctrl_reg;
  logic [7:0]   pen_reg;
  logic [7:0]   swcfg_reg;
  logic [7:0]   limcfg_reg;
  logic [7:0]   tmo_reg [CES_NPROF];
  logic         aw_got_reg;
  logic         w_got_reg;
  logic [9:0]   awidx_reg;
  logic [7:0]   wbyte_reg;
  logic         wlane_reg;
  logic [15:0]  tick_cnt_reg;
  logic         ms_tick;
  logic [7:0]   tmr_reg;
  ces_state_t   state_reg;
  ces_state_t   state_next;
  logic [2:0]   pos_reg;
  logic [2:0]   pos_next;
  ces_mode_t    mode;
  ces_mode_t    mode_last_reg;
  logic         accepted_reg;
  logic [2:0]   acc_prof_reg;
  logic [2:0]   cur_prof;
  logic [3:0]   first_pos;
  logic [3:0]   nxt_pos;
  logic         expire;
  logic         wr_en;
  logic         cc_next;
  logic         hs_next;
  logic [3:0]   sig_next;

  wire pwr     = ctrl_reg[CES_CTRL_PWR_BIT];
  wire att_en  = ctrl_reg[CES_CTRL_ATT_BIT];
  wire cfirst  = ctrl_reg[CES_CTRL_CF_BIT];
  wire retry   = ctrl_reg[CES_CTRL_RTY_BIT];
  wire tmo_en  = ctrl_reg[CES_CTRL_TMO_BIT];
  wire hs_cfg  = swcfg_reg[CES_SWCFG_HS_BIT];

  // sequence position to profile number
  // [RULE10] custom first shifts legacy by one
  function automatic logic [2:0] prof_of(input logic [2:0] p,
                                         input logic       cf);
    if (cf)
      prof_of = (p == 3'h0) ? CES_PROF_CUST : p - 3'h1;
    else
      prof_of = p;
  endfunction : prof_of

  // lowest enabled position at or after start, msb marks found
  function automatic logic [3:0] find_pos(input logic [3:0] start,
                                          input logic [7:0] en,
                                          input logic       cf);
    logic [3:0] res;
    res = 4'h0;
    for (int i = CES_NPROF - 1; i >= 0; i--)
    begin
      if (4'(i) >= start && en[prof_of(3'(i), cf)])
        res = {1'b1, 3'(i)};
    end
    return res;
  endfunction : find_pos

  assign mode      = ces_mode_t'(ctrl_reg[CES_CTRL_MODE_LSB +: 3]);
  assign cur_prof  = prof_of(pos_reg, cfirst);
  // [RULE9] fixed order
  assign first_pos = find_pos(4'h0, pen_reg, cfirst);
  assign nxt_pos   = find_pos({1'b0, pos_reg} + 4'h1, pen_reg, cfirst);
  // [RULE5] expiry of profile timer
  assign expire    = state_reg == CES_ST_APPLY && ms_tick &&
                     tmr_reg >= tmo_reg[cur_prof];
  assign ms_tick   = tick_cnt_reg == 16'(MS_TICK_CYCLES - 1);

  // millisecond tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn || ms_tick)
      tick_cnt_reg <= 16'h0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end

  // write channel capture
  assign wr_en = aw_got_reg && w_got_reg && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awidx_reg     <= 10'h000;
      wbyte_reg     <= 8'h00;
      wlane_reg     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CES_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg    <= 1'b1;
        awidx_reg     <= s_axi_awaddr[CES_AW-1:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg    <= 1'b1;
        wbyte_reg    <= s_axi_wdata[7:0];
        wlane_reg    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(awidx_reg) && awidx_reg != CES_IDX_STAT ?
                        CES_RESP_OKAY : CES_RESP_SLV;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_got_reg    <= 1'b0;
        w_got_reg     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  function automatic logic addr_ok(input logic [9:0] idx);
    addr_ok = idx == CES_IDX_CTRL || idx == CES_IDX_PEN ||
              idx == CES_IDX_SWCFG || idx == CES_IDX_STAT ||
              idx == CES_IDX_LIMCFG || idx[9:3] == CES_IDX_TMO0[9:3];
  endfunction : addr_ok

  // configuration registers, low byte lane only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg   <= CES_CTRL_RST;
      pen_reg    <= CES_PEN_RST;
      swcfg_reg  <= CES_SWCFG_RST;
      limcfg_reg <= CES_LIMCFG_RST;
      for (int i = 0; i < CES_NPROF; i++)
        tmo_reg[i] <= CES_TMO_RST;
    end
    else if (wr_en && wlane_reg)
    begin
      case (awidx_reg)
        CES_IDX_CTRL:   ctrl_reg   <= wbyte_reg;
        CES_IDX_PEN:    pen_reg    <= wbyte_reg;
        CES_IDX_SWCFG:  swcfg_reg  <= wbyte_reg;
        CES_IDX_LIMCFG: limcfg_reg <= wbyte_reg;
        default:
        begin
          // [RULE14] one timeout per profile
          if (awidx_reg[9:3] == CES_IDX_TMO0[9:3])
            tmo_reg[awidx_reg[2:0]] <= wbyte_reg;
        end
      endcase
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= CES_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= addr_ok(s_axi_araddr[CES_AW-1:2]) ?
                       CES_RESP_OKAY : CES_RESP_SLV;
      case (s_axi_araddr[CES_AW-1:2])
        CES_IDX_CTRL:   s_axi_rdata <= {24'h000000, ctrl_reg};
        CES_IDX_PEN:    s_axi_rdata <= {24'h000000, pen_reg};
        CES_IDX_SWCFG:  s_axi_rdata <= {24'h000000, swcfg_reg};
        CES_IDX_LIMCFG: s_axi_rdata <= {24'h000000, limcfg_reg};
        CES_IDX_STAT:
          s_axi_rdata <= {16'h0000, state_reg, pos_reg,
                          acc_prof_reg, accepted_reg,
                          handshake_missing_flag};
        default:
        begin
          if (s_axi_araddr[CES_AW-1:5] == CES_IDX_TMO0[9:3])
            s_axi_rdata <= {24'h000000, tmo_reg[s_axi_araddr[4:2]]};
          else
            s_axi_rdata <= '0;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    pos_next   = pos_reg;
    if (!pwr || mode != mode_last_reg)
      state_next = CES_ST_IDLE;
    else
    begin
      case (state_reg)
        CES_ST_IDLE:
        begin
          if (mode == CES_MODE_DCE)
          begin
            // [RULE11] free cycling without attach detect
            if (!att_en || attach_detected)
            begin
              state_next = CES_ST_DISCH;
              pos_next   = first_pos[2:0];
            end
          end
          else if (mode == CES_MODE_SDP || mode == CES_MODE_CDP ||
                   mode == CES_MODE_DCP)
            // [RULE1] discharge before signature
            state_next = CES_ST_DISCH;
          else
            state_next = CES_ST_PASS;
        end
        CES_ST_DISCH:
        begin
          // [RULE7] discharge period
          if (ms_tick && tmr_reg >= CES_DISCH_MS)
            state_next = CES_ST_HOLD;
        end
        CES_ST_HOLD:
        begin
          // [RULE8] hold open then reapply vbus
          if (ms_tick && tmr_reg >= CES_HREST_MS)
          begin
            if (mode == CES_MODE_DCP)
              state_next = CES_ST_DCP;
            else if (mode != CES_MODE_DCE)
              state_next = CES_ST_PASS;
            else if (pen_reg[cur_prof])
              state_next = CES_ST_APPLY;
            else if (retry)
            begin
              state_next = CES_ST_DISCH;
              pos_next   = first_pos[2:0];
            end
            else
              state_next = CES_ST_NOHS;
          end
        end
        CES_ST_APPLY:
        begin
          if (!tmo_en)
            state_next = CES_ST_CHARGE;
          else if (expire)
          begin
            // [RULE24] current sampled only at expiry
            if (charge_detect)
              // [RULE12] accept and stop
              state_next = CES_ST_CHARGE;
            else if (nxt_pos[3])
            begin
              // [RULE13] reject, reset, next profile
              state_next = CES_ST_DISCH;
              pos_next   = nxt_pos[2:0];
            end
            else if (retry)
            begin
              // [RULE15] restart the cycle
              state_next = CES_ST_DISCH;
              pos_next   = first_pos[2:0];
            end
            else
              // [RULE16] end cycle without handshake
              state_next = CES_ST_NOHS;
          end
        end
        // [RULE2] dcp holds: no timer, no current check
        CES_ST_CHARGE,
        CES_ST_NOHS,
        CES_ST_DCP,
        CES_ST_PASS:
          state_next = state_reg;
        default:
          state_next = CES_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= CES_ST_IDLE;
      pos_reg       <= 3'h0;
      mode_last_reg <= CES_MODE_PASS;
    end
    else
    begin
      state_reg     <= state_next;
      pos_reg       <= pos_next;
      mode_last_reg <= mode;
    end
  end

  // phase timer in milliseconds, restarts on every state change
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_next != state_reg)
      tmr_reg <= 8'h00;
    else if (ms_tick && tmr_reg != 8'hFF)
      tmr_reg <= tmr_reg + 8'h01;
  end

  // status: set wins over clear at the start of a new cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      handshake_missing_flag <= 1'b0;
      accepted_reg           <= 1'b0;
      acc_prof_reg           <= 3'h0;
    end
    else
    begin
      if (state_reg == CES_ST_IDLE && state_next == CES_ST_DISCH)
      begin
        handshake_missing_flag <= 1'b0;
        accepted_reg           <= 1'b0;
      end
      if (state_reg == CES_ST_APPLY && state_next == CES_ST_CHARGE)
      begin
        accepted_reg <= 1'b1;
        acc_prof_reg <= cur_prof;
      end
      // [RULE22] sticky no handshake flag
      if (state_next == CES_ST_NOHS)
        handshake_missing_flag <= 1'b1;
    end
  end

  // limiting mode, switch and signature selection
  always_comb
  begin
    cc_next  = 1'b0;
    hs_next  = 1'b0;
    sig_next = CES_SIG_NONE;
    case (state_next)
      CES_ST_PASS:
      begin
        hs_next = 1'b1;
        // [RULE17] trip for pass-through and sdp
        cc_next = mode == CES_MODE_CDP && ilim_below_thresh;
      end
      CES_ST_DCP:
      begin
        // [RULE4] signature static, no detection response
        sig_next = CES_SIG_DCP;
        // [RULE3] switch open, cc below threshold
        cc_next  = ilim_below_thresh;
      end
      CES_ST_APPLY:
      begin
        sig_next = {1'b0, prof_of(pos_next, cfirst)} + 4'h1;
        // [RULE6] data switch open unless configured
        hs_next  = hs_cfg;
        // [RULE18] cc while profile applied
        cc_next  = ilim_below_thresh;
      end
      CES_ST_CHARGE:
      begin
        sig_next = {1'b0, cur_prof} + 4'h1;
        hs_next  = hs_cfg;
        // [RULE19] legacy three keeps cc rule
        if (cur_prof == CES_PROF_L3)
          cc_next = ilim_below_thresh;
        else
          // [RULE20] region two compare decides
          cc_next = ilim_below_thresh && !r2min_below_limit;
      end
      CES_ST_NOHS:
      begin
        // [RULE23] signatures removed, switch configured
        hs_next = hs_cfg;
        cc_next = ilim_below_thresh && !r2min_below_limit;
      end
      default:
      begin
        cc_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_switch_close   <= 1'b0;
      vbus_discharge      <= 1'b0;
      pulldown_enable     <= 1'b0;
      short_resistor_on   <= 1'b0;
      hs_switch_close     <= 1'b0;
      cc_limit_mode       <= 1'b0;
      signature_sel       <= CES_SIG_NONE;
      region2_min_current <= 3'h0;
    end
    else
    begin
      // [RULE7] switch open, discharge, pull-downs
      port_switch_close <= state_next == CES_ST_PASS ||
                           state_next == CES_ST_DCP ||
                           state_next == CES_ST_APPLY ||
                           state_next == CES_ST_CHARGE ||
                           state_next == CES_ST_NOHS;
      vbus_discharge    <= state_next == CES_ST_DISCH;
      pulldown_enable   <= state_next == CES_ST_DISCH ||
                           state_next == CES_ST_HOLD;
      short_resistor_on <= sig_next == CES_SIG_DCP;
      hs_switch_close   <= hs_next;
      cc_limit_mode     <= cc_next;
      signature_sel     <= sig_next;
      // [RULE21] region two field bits four..two
      region2_min_current <= limcfg_reg[CES_LIM_R2_LSB +: 3];
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reject_retry;
    expire && tmo_en && !charge_detect && !nxt_pos[3] && retry && pwr &&
      mode == mode_last_reg;
  endsequence
  sequence s_reset_then_apply;
    state_reg == CES_ST_HOLD ##1 state_reg == CES_ST_APPLY;
  endsequence

  AST_APPLY_AFTER_RESET: assert property ( // RULE7
    $rose(state_reg == CES_ST_APPLY) |-> $past(state_reg) == CES_ST_HOLD)
    else $error("profile applied without emulation reset");
  AST_SWITCH_OPEN_RESET: assert property ( // RULE8
    s_reset_then_apply |-> port_switch_close && !$past(port_switch_close))
    else $error("switch not reclosed after reset hold");
  AST_DCP_OUTPUTS: assert property ( // RULE3
    state_reg == CES_ST_DCP && $past(state_reg) == CES_ST_DCP |->
      short_resistor_on && !hs_switch_close &&
      cc_limit_mode == $past(ilim_below_thresh))
    else $error("dcp charging outputs wrong");
  AST_ACCEPT: assert property ( // RULE12
    expire && charge_detect && pwr && mode == mode_last_reg |=>
      state_reg == CES_ST_CHARGE && accepted_reg)
    else $error("profile not accepted on charge current");
  AST_REJECT_NEXT: assert property ( // RULE13
    expire && tmo_en && !charge_detect && nxt_pos[3] && pwr &&
      mode == mode_last_reg |=>
      vbus_discharge && pos_reg == $past(nxt_pos[2:0]))
    else $error("rejected profile not followed by reset");
  AST_RETRY: assert property ( // RULE15
    s_reject_retry |=> vbus_discharge ##0 pos_reg == $past(first_pos[2:0]))
    else $error("cycle not restarted on retry");
  AST_NOHS_FLAG: assert property ( // RULE22
    state_reg == CES_ST_NOHS |-> handshake_missing_flag &&
      signature_sel == CES_SIG_NONE && !short_resistor_on)
    else $error("no handshake state without flag or clean pins");
  AST_PASS_TRIP: assert property ( // RULE17
    state_reg == CES_ST_PASS && $past(mode) != CES_MODE_CDP |->
      !cc_limit_mode && hs_switch_close)
    else $error("pass-through not in trip mode");
  AST_DCE_SWITCH: assert property ( // RULE6
    state_reg == CES_ST_CHARGE && !$past(hs_cfg) |-> !hs_switch_close)
    else $error("data switch closed while charging");

endmodule : ces_sequencer

// *** test/ces_port_device.sv ***
`timescale 1ns/1ps
module ces_port_device (
  // clock
  input  wire logic       aclk,
  // port side
  input  wire logic       port_switch_close,
  input  wire logic [3:0] signature_sel,
  input  wire logic [3:0] accept_sig,
  // current sense
  output logic            charge_detect
);
  // draws charge current only when powered under the signature it knows
  always_ff @(posedge aclk)
  begin
    charge_detect <= port_switch_close && (accept_sig != 4'h0)
                     && (signature_sel == accept_sig);
  end
endmodule : ces_port_device

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import ces_pkg::*;
  logic        aclk = 0, aresetn = 0, dseen = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, signature_sel, acc = 0, last = 0;
  logic [2:0]  region2_min_current, r2;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        charge_detect, ilim_below_thresh = 1, attach_detected = 0;
  logic        r2min_below_limit = 0, port_switch_close, vbus_discharge;
  logic        pulldown_enable, short_resistor_on, hs_switch_close;
  logic        cc_limit_mode, handshake_missing_flag;
  logic [65:0] exp_q[$], e;
  logic [3:0]  rec[$];
  logic [3:0]  seq_l[4] = '{4'h8, 4'h3, 4'h8, 4'h3};
  int          n_fail = 0, checks = 0, i, sz;

  always #50 aclk = ~aclk;

  ces_sequencer #(.MS_TICK_CYCLES(4)) i_dut (.*);
  ces_port_device i_dev (.aclk(aclk), .port_switch_close(port_switch_close),
    .signature_sel(signature_sel), .accept_sig(acc),
    .charge_detect(charge_detect));

  task automatic print_verdict;
    begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask : print_verdict

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    begin
      checks++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask : chk

  task automatic tmo(input bit hit);
    begin
      if (hit)
      begin
        n_fail++;
        print_verdict();
      end
    end
  endtask : tmo

  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n;
    begin
      n = 0;
      exp_q.push_back({r, 64'h0});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        n++;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 99);
      s_axi_bready <= 1'b0;
      tmo(n >= 99);
    end
  endtask : axw

  task automatic axr(input logic [11:0] a, input logic [31:0] d, m,
                     input logic [1:0] r);
    int n;
    begin
      n = 0;
      exp_q.push_back({r, m, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        n++;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 99);
      s_axi_rready <= 1'b0;
      tmo(n >= 99);
    end
  endtask : axr

  // answers and profile sequence watcher
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
    begin
      e = exp_q.pop_front();
      chk({32'h0, s_axi_bresp}, {32'h0, e[65:64]});
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = exp_q.pop_front();
      chk({s_axi_rresp, s_axi_rdata & e[63:32]},
          {e[65:64], e[31:0] & e[63:32]});
    end
    if (vbus_discharge === 1'b1)
    begin
      dseen = 1'b1;
      chk({32'h0, pulldown_enable, port_switch_close}, 34'h2);
    end
    if (signature_sel !== last)
    begin
      if (signature_sel != 4'h0)
      begin
        rec.push_back(signature_sel);
        chk({32'h0, dseen, port_switch_close}, 34'h3);
        dseen = 1'b0;
      end
      last = signature_sel;
    end
  end

  initial
  begin
    void'($urandom(32'h8A462BFE));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(12'h000, 32'hC0, 32'hFFFFFFFF, CES_RESP_OKAY);
    axr(12'h004, 32'h7F, 32'hFFFFFFFF, CES_RESP_OKAY);
    axr(12'h020, 32'h20, 32'hFFFFFFFF, CES_RESP_OKAY);
    axr(12'hFFC, 32'h0, 32'hFFFFFFFF, CES_RESP_SLV);
    axw(12'h00C, 32'h1, CES_RESP_SLV);
    // standalone dcp: no timeout, device draws nothing
    axw(12'h000, 32'h8B, CES_RESP_OKAY);
    repeat (900) @(posedge aclk);
    chk({signature_sel, short_resistor_on, hs_switch_close, cc_limit_mode},
        {CES_SIG_DCP, 3'b101});
    // cycle without retry, nobody answers
    rec.delete();
    r2 = 3'($urandom);
    r2min_below_limit <= 1'($urandom);
    axw(12'h144, {27'h0, r2, 2'h0}, CES_RESP_OKAY);
    axw(12'h000, 32'h8C, CES_RESP_OKAY);
    for (i = 0; i < 5000 && handshake_missing_flag !== 1'b1; i++)
      @(posedge aclk);
    tmo(i >= 5000);
    chk(rec.size(), 7);
    for (i = 0; i < 7 && i < rec.size(); i++)
      chk(rec[i], i + 1);
    chk({signature_sel, hs_switch_close, region2_min_current, cc_limit_mode},
        {CES_SIG_NONE, 1'b0, r2, !r2min_below_limit});
    repeat (50) @(posedge aclk);
    axr(12'h00C, 32'h1, 32'h1, CES_RESP_OKAY);
    // pass-through uses trip limiting even with a low limit
    axw(12'h000, 32'h88, CES_RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk(cc_limit_mode, 1'b0);
    // cdp after discharge: data switch closed, cc with a low limit
    axw(12'h000, 32'h8A, CES_RESP_OKAY);
    repeat (300) @(posedge aclk);
    chk({cc_limit_mode, hs_switch_close}, 2'b11);
    // custom first with retry, then legacy three accepted
    rec.delete();
    axw(12'h004, 32'h84, CES_RESP_OKAY);
    axw(12'h000, 32'hEC, CES_RESP_OKAY);
    for (i = 0; i < 3000 && rec.size() < 4; i++)
      @(posedge aclk);
    tmo(i >= 3000);
    for (i = 0; i < 4; i++)
      chk(rec[i], seq_l[i]);
    acc <= CES_SIG_DCP;
    repeat (1500) @(posedge aclk);
    sz = rec.size();
    repeat (400) @(posedge aclk);
    chk(rec.size(), sz);
    chk({signature_sel, short_resistor_on, hs_switch_close, cc_limit_mode,
         handshake_missing_flag}, {CES_SIG_DCP, 4'hA});
    axr(12'h00C, {27'h0, CES_PROF_L3, 2'h2}, 32'h1F, CES_RESP_OKAY);
    print_verdict();
  end
endmodule : tb_top
